// file: verilog/conv_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CONV_DEFINES_SVH
`define CONV_DEFINES_SVH

`define OFF_CONFIG 4'h0
`define OFF_DIVIDER 4'h4
`define OFF_STATUS 4'h8
`define OFF_MASK 4'hC

`define CFG_REF_BIT 7
`define CFG_JUST_HI 6
`define CFG_JUST_LO 5
`define CFG_RSVD_BIT 4
`define CFG_GO_BIT 3
`define CFG_CHAN_HI 2
`define CFG_CHAN_LO 0
`define CFG_WRITE_MASK 8'hEF

`define CONFIG_RESET 8'h00
`define DIVIDER_RESET 8'h00
`define REF_PERIOD_NS 1736
`define CLK_PERIOD_NS 4
`define REF_PERIOD_CYCLES (`REF_PERIOD_NS / `CLK_PERIOD_NS)

`define EVT_DONE_BIT 0
`define EVT_BAD_JUST_BIT 1

`endif

// file: verilog/conv_pkg.sv
// Types shared by the converter control files
package conv_pkg;
    typedef enum logic [1:0] {
        JUST_RIGHT = 2'h0,
        JUST_SIGNED = 2'h1,
        JUST_LEFT = 2'h2,
        JUST_RSVD = 2'h3
    } justify_e;

    typedef struct packed {
        logic reference_select;
        justify_e result_justify;
        logic reserved;
        logic start_done;
        logic [2:0] channel_select;
    } config_s;

    typedef struct packed {
        logic start;
        logic use_ext_ref;
        justify_e justify;
        logic [2:0] channel;
    } conv_req_s;
endpackage

// file: verilog/ref_clock_gen.sv
// Reference clock generator driven by the divider count
`timescale 1ns/1ps
`include "conv_defines.svh"
module ref_clock_gen (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] divider,
    output logic ref_tick,
    output logic ref_clk
);
    logic [7:0] count;
    logic [7:0] next_count;
    logic next_tick;
    logic next_ref_clk;

    // Tick every divider+1 cycles; a zero divider ticks every cycle
    always_comb begin
        next_count = count + 8'h01;
        next_tick = 1'b0;
        next_ref_clk = ref_clk;
        if (count >= divider) begin
            next_count = 8'h00;
            next_tick = 1'b1;
            next_ref_clk = ~ref_clk;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= 8'h00;
            ref_tick <= 1'b0;
            ref_clk <= 1'b0;
        end else begin
            count <= next_count;
            ref_tick <= next_tick;
            ref_clk <= next_ref_clk;
        end
    end

    a_tick_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
        (ref_tick && divider == 8'h01) ##1 (divider == 8'h01)
        |-> !ref_tick ##1 ref_tick)
        else $error("Reference tick spacing wrong");
endmodule

// file: verilog/conv_control.sv
// Converter control block with AXI4-Lite register access
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "conv_defines.svh"
module conv_control (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [3:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    output conv_pkg::conv_req_s conv_req,
    output logic ref_clk,
    input wire logic conv_done,
    output logic irq
);
    // -------------------------------------------------------------------
    // Register state
    // -------------------------------------------------------------------
    conv_pkg::config_s cfg;
    conv_pkg::config_s next_cfg;
    logic [7:0] divider;
    logic [7:0] next_divider;
    logic [1:0] status;
    logic [1:0] next_status;
    logic [1:0] mask;
    logic [1:0] next_mask;
    logic busy;
    logic next_busy;
    logic done_s1;
    logic done_s2;
    logic done_prev;
    logic ref_tick;
    conv_pkg::conv_req_s next_conv_req;

    // -------------------------------------------------------------------
    // Bus write channel
    // -------------------------------------------------------------------
    logic aw_held;
    logic next_aw_held;
    logic w_held;
    logic next_w_held;
    logic [3:0] aw_addr;
    logic [3:0] next_aw_addr;
    logic [31:0] w_data;
    logic [31:0] next_w_data;
    logic w_strb0;
    logic next_w_strb0;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic wr_fire;
    logic [1:0] next_rresp;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic done_edge;

    function automatic logic mapped(input logic [3:0] a);
        mapped = (a == `OFF_CONFIG) || (a == `OFF_DIVIDER) ||
                 (a == `OFF_STATUS) || (a == `OFF_MASK);
    endfunction

    assign s_awready = !aw_held && !s_bvalid;
    assign s_wready = !w_held && !s_bvalid;
    assign s_arready = !s_rvalid;
    assign wr_fire = aw_held && w_held && !s_bvalid;
    assign done_edge = done_s2 && !done_prev;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb0 = w_strb0;
        next_bvalid = s_bvalid;
        next_bresp = s_bresp;
        if (s_awvalid && s_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_wdata;
            next_w_strb0 = s_wstrb[0];
        end
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = mapped(aw_addr) ? 2'h0 : 2'h2;
        end else if (s_bvalid && s_bready) begin
            next_bvalid = 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // Register updates
    // -------------------------------------------------------------------
    always_comb begin
        next_cfg = cfg;
        next_divider = divider;
        next_mask = mask;
        next_status = status;
        next_busy = busy;
        if (busy && done_edge) begin
            next_busy = 1'b0;
            next_status[`EVT_DONE_BIT] = 1'b1;
        end
        if (wr_fire && w_strb0) begin
            unique case (aw_addr)
                `OFF_CONFIG: begin
                    // Reserved bit masked off so it always reads zero
                    next_cfg = conv_pkg::config_s'(w_data[7:0] &
                        `CFG_WRITE_MASK);
                    next_cfg.start_done = 1'b0;
                    if (w_data[`CFG_GO_BIT]) begin
                        next_busy = 1'b1;
                    end
                    if (w_data[`CFG_JUST_HI:`CFG_JUST_LO] == 2'h3) begin
                        next_status[`EVT_BAD_JUST_BIT] = 1'b1;
                    end
                end
                `OFF_DIVIDER: next_divider = w_data[7:0];
                // Set wins over clear: a fresh event stays pending
                `OFF_STATUS: next_status = next_status &
                    ~(w_data[1:0] & ~(status ^ next_status));
                `OFF_MASK: next_mask = w_data[1:0];
                default: ;
            endcase
        end
        next_cfg.start_done = next_busy;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0;
            w_strb0 <= 1'b0;
            s_bvalid <= 1'b0;
            s_bresp <= 2'h0;
            cfg <= `CONFIG_RESET;
            divider <= `DIVIDER_RESET;
            mask <= 2'h0;
            status <= 2'h0;
            busy <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb0 <= next_w_strb0;
            s_bvalid <= next_bvalid;
            s_bresp <= next_bresp;
            cfg <= next_cfg;
            divider <= next_divider;
            mask <= next_mask;
            status <= next_status;
            busy <= next_busy;
        end
    end

    // -------------------------------------------------------------------
    // Read channel
    // -------------------------------------------------------------------
    always_comb begin
        next_rvalid = s_rvalid;
        next_rdata = s_rdata;
        next_rresp = s_rresp;
        if (s_arvalid && s_arready) begin
            next_rvalid = 1'b1;
            next_rresp = 2'h0;
            next_rdata = 32'h0;
            unique case (s_araddr)
                `OFF_CONFIG: next_rdata = {24'h0, cfg};
                `OFF_DIVIDER: next_rdata = {24'h0, divider};
                `OFF_STATUS: next_rdata = {30'h0, status};
                `OFF_MASK: next_rdata = {30'h0, mask};
                default: next_rresp = 2'h2;
            endcase
        end else if (s_rvalid && s_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0;
            s_rresp <= 2'h0;
        end else begin
            s_rvalid <= next_rvalid;
            s_rdata <= next_rdata;
            s_rresp <= next_rresp;
        end
    end

    // -------------------------------------------------------------------
    // Converter side
    // -------------------------------------------------------------------
    always_comb begin
        next_conv_req.start = busy;
        next_conv_req.use_ext_ref = cfg.reference_select;
        next_conv_req.justify = cfg.result_justify;
        next_conv_req.channel = cfg.channel_select;
    end

    // Done comes from the analog core, so it is synchronised first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
            done_prev <= 1'b0;
            conv_req <= '0;
        end else begin
            done_s1 <= conv_done;
            done_s2 <= done_s1;
            done_prev <= done_s2;
            conv_req <= next_conv_req;
        end
    end

    assign irq = |(status & mask);

    ref_clock_gen u_ref_clock_gen (
        .aclk(aclk),
        .aresetn(aresetn),
        .divider(divider),
        .ref_tick(ref_tick),
        .ref_clk(ref_clk)
    );

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    a_go_starts: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && w_strb0 && aw_addr == `OFF_CONFIG &&
         w_data[`CFG_GO_BIT]) |=> busy ##1 conv_req.start)
        else $error("Start write did not begin conversion");
    a_busy_reads_one: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_arvalid && s_arready && s_araddr == `OFF_CONFIG)
        |=> s_rdata[`CFG_GO_BIT] == $past(busy))
        else $error("start_done does not track busy");
    a_done_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        (busy && done_edge && !(wr_fire && aw_addr == `OFF_CONFIG))
        |=> !cfg.start_done && status[`EVT_DONE_BIT])
        else $error("Finished conversion not reported");
    a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        !cfg.reserved)
        else $error("Reserved bit set");
    a_ref_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(cfg.reference_select) |=>
        conv_req.use_ext_ref == $past(cfg.reference_select))
        else $error("Reference select not forwarded");
    a_chan_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 conv_req.channel == $past(cfg.channel_select))
        else $error("Channel select not forwarded");
    a_just_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 conv_req.justify == $past(cfg.result_justify))
        else $error("Justify not forwarded");
    a_divider_load: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && w_strb0 && aw_addr == `OFF_DIVIDER)
        |=> divider == $past(w_data[7:0]))
        else $error("Divider not loaded");
    a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
        irq == |(status & mask))
        else $error("Interrupt level wrong");
    a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_bvalid && !s_bready) |=> s_bvalid && $stable(s_bresp))
        else $error("Write response dropped early");
    a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_rvalid && !s_rready) |=> s_rvalid && $stable(s_rdata) &&
        $stable(s_rresp))
        else $error("Read response dropped early");
    a_read_unmapped: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_arvalid && s_arready && !mapped(s_araddr))
        |=> s_rresp == 2'h2 && s_rdata == 32'h0)
        else $error("Unmapped read not refused");
    a_write_unmapped: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && !mapped(aw_addr)) |=> s_bvalid && s_bresp == 2'h2)
        else $error("Unmapped write not refused");
    a_start_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 conv_req.start == $past(busy))
        else $error("Start not forwarded");
    a_just_flagged: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && w_strb0 && aw_addr == `OFF_CONFIG &&
         w_data[`CFG_JUST_HI:`CFG_JUST_LO] == 2'h3)
        |=> status[`EVT_BAD_JUST_BIT])
        else $error("Reserved justify code not flagged");
    a_status_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        (status[`EVT_DONE_BIT] &&
         !(wr_fire && w_strb0 && aw_addr == `OFF_STATUS))
        |=> status[`EVT_DONE_BIT])
        else $error("Done flag lost without a clear");
    a_strobe_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && !w_strb0) |=> $stable(divider) && $stable(mask))
        else $error("Write without strobe took effect");
    a_rsvd_readback: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_arvalid && s_arready && s_araddr == `OFF_CONFIG)
        |=> !s_rdata[`CFG_RSVD_BIT])
        else $error("Reserved bit read back as one");
    a_done_synced: assert property (@(posedge aclk) disable iff (!aresetn)
        done_edge |-> $past(conv_done, 2))
        else $error("Done edge not synchronised");
endmodule

// file: tb/conv_core_model.sv
// Behavioural model of the analog converter core behind the control block
`timescale 1ns/1ps
module conv_core_model (
    input wire logic aclk,
    input wire logic aresetn,
    input conv_pkg::conv_req_s conv_req,
    input wire logic [7:0] delay,
    output logic conv_done,
    output int starts
);
    int cnt;
    logic run;
    // Done is held until start drops, so every conversion gives a fresh edge
    always @(posedge aclk) begin
        if (!aresetn) begin
            conv_done <= 1'b0;
            starts <= 0;
            run <= 1'b0;
            cnt <= 0;
        end else if (conv_req.start && !run && !conv_done) begin
            run <= 1'b1;
            starts <= starts + 1;
            cnt <= delay;
        end else if (run && cnt > 0) begin
            cnt <= cnt - 1;
        end else if (run) begin
            run <= 1'b0;
            conv_done <= 1'b1;
        end else if (!conv_req.start) begin
            conv_done <= 1'b0;
        end
    end
endmodule

// file: tb/conv_control_tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "conv_defines.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
    bad_count++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module conv_control_tb_top;
    typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} note_s;
    logic aclk = 0, aresetn = 0;
    logic [3:0] s_awaddr = 0, s_wstrb = 0, s_araddr = 0;
    logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0;
    logic s_rready = 0, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [31:0] s_wdata = 0, s_rdata;
    logic [1:0] s_bresp, s_rresp;
    conv_pkg::conv_req_s conv_req;
    logic ref_clk, conv_done, irq;
    logic [7:0] delay = 8'h1E;
    int starts, bad_count = 0, tests_run = 0, seed = 32'had3c00d8;
    note_s rq[$];
    logic [1:0] bq[$];
    conv_control conv_control_i (.aclk(aclk), .aresetn(aresetn),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
        .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
        .s_rvalid(s_rvalid), .s_rready(s_rready), .conv_req(conv_req),
        .ref_clk(ref_clk), .conv_done(conv_done), .irq(irq));
    conv_core_model conv_core_model_i (.aclk(aclk), .aresetn(aresetn),
        .conv_req(conv_req), .delay(delay), .conv_done(conv_done),
        .starts(starts));
    always #2 aclk = ~aclk;
    // ----------------------------------------
    // Bus master tasks and reference clock period measurement
    // ----------------------------------------
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] r);
        int n;
        logic ah, wh, ta, tw;
        n = 0;
        ah = 1'b1;
        wh = 1'b1;
        bq.push_back(r);
        s_awaddr <= a;
        s_wdata <= d;
        s_wstrb <= s;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        // Each channel is released at the edge that takes it
        while ((ah || wh) && n < 100) begin
            @(negedge aclk);
            ta = ah && s_awready;
            tw = wh && s_wready;
            @(posedge aclk);
            if (ta) begin
                s_awvalid <= 1'b0;
                ah = 1'b0;
            end
            if (tw) begin
                s_wvalid <= 1'b0;
                wh = 1'b0;
            end
            n++;
        end
        do begin
            @(negedge aclk);
            n++;
        end while (s_bvalid !== 1'b1 && n < 200);
        @(posedge aclk);
        if (n >= 200) bad_count++;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e,
                      input logic [31:0] m, input logic [1:0] r,
                      output logic [31:0] q);
        int n;
        n = 0;
        rq.push_back('{e, m, r});
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(negedge aclk);
            n++;
        end while (s_arready !== 1'b1 && n < 100);
        @(posedge aclk);
        s_arvalid <= 1'b0;
        do begin
            @(negedge aclk);
            n++;
        end while (s_rvalid !== 1'b1 && n < 200);
        @(posedge aclk);
        q = s_rdata;
        if (n >= 200) bad_count++;
    endtask
    task automatic ref_period(output int n);
        int c;
        logic p;
        n = 0;
        c = 0;
        p = ref_clk;
        while (c < 3 && n < 2000) begin
            @(negedge aclk);
            n++;
            if (ref_clk && !p) begin
                c++;
                if (c < 3) n = 0;
            end
            p = ref_clk;
        end
    endtask
    // Results are judged where they appear, against the oldest note
    always @(posedge aclk) begin
        note_s t;
        logic [1:0] b;
        if (s_rvalid && s_rready) begin
            t = rq.pop_front();
            `CHK("rdata", t.d & t.m, s_rdata & t.m)
            `CHK("rresp", t.r, s_rresp)
        end
        if (s_bvalid && s_bready) begin
            b = bq.pop_front();
            `CHK("bresp", b, s_bresp)
        end
    end
    task automatic complete_run;
        if (bad_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #300000;
        bad_count++;
        complete_run();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] q;
        logic [7:0] c, e;
        int n, d;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`OFF_CONFIG, 0, 32'hFFFFFFFF, 2'h0, q);
        rd(`OFF_DIVIDER, 0, 32'hFFFFFFFF, 2'h0, q);
        for (int i = 0; i < 8; i++) begin
            c = {i[0], 2'(i % 3), 1'($random(seed)), 1'b0, i[2:0]};
            e = c & `CFG_WRITE_MASK;
            wr(`OFF_CONFIG, {24'($random(seed)), c}, 4'hF, 2'h0);
            rd(`OFF_CONFIG, e, 32'hFFFFFFFF, 2'h0, q);
            `CHK("channel", i[2:0], conv_req.channel)
            `CHK("justify", 2'(i % 3), conv_req.justify)
            `CHK("ext_ref", i[0], conv_req.use_ext_ref)
        end
        wr(`OFF_CONFIG, 32'hFF, 4'h0, 2'h0);
        rd(`OFF_CONFIG, e, 32'hFFFFFFFF, 2'h0, q);
        wr(`OFF_CONFIG, 32'h60, 4'hF, 2'h0);
        rd(`OFF_STATUS, 32'h2, 32'hFFFFFFFF, 2'h0, q);
        wr(`OFF_STATUS, 32'h2, 4'hF, 2'h0);
        wr(4'h2, 32'h1, 4'hF, 2'h2);
        rd(4'h2, 0, 32'hFFFFFFFF, 2'h2, q);
        for (int k = 0; k < 2; k++) begin
            delay <= k ? 8'h01 : 8'h28;
            wr(`OFF_CONFIG, 32'h0D, 4'hF, 2'h0);
            rd(`OFF_CONFIG, 32'h08, k ? 0 : 32'h08, 2'h0, q);
            n = 0;
            do begin
                rd(`OFF_CONFIG, 0, 0, 2'h0, q);
                n++;
            end while (q[3] !== 1'b0 && n < 50);
            rd(`OFF_CONFIG, 32'h05, 32'hFF, 2'h0, q);
            rd(`OFF_STATUS, 32'h1, 32'h1, 2'h0, q);
            `CHK("starts", k + 1, starts)
        end
        wr(`OFF_MASK, 32'h0, 4'hF, 2'h0);
        `CHK("irq off", 1'b0, irq)
        wr(`OFF_MASK, 32'h1, 4'hF, 2'h0);
        `CHK("irq on", 1'b1, irq)
        rd(`OFF_MASK, 32'h1, 32'hFF, 2'h0, q);
        wr(`OFF_STATUS, 32'h1, 4'hF, 2'h0);
        `CHK("irq clr", 1'b0, irq)
        rd(`OFF_STATUS, 0, 32'hFF, 2'h0, q);
        for (int k = 0; k < 3; k++) begin
            d = k ? 1 : $random(seed) & 7;
            if (k == 2) d = (`REF_PERIOD_CYCLES / 2) - 1;
            wr(`OFF_DIVIDER, d, 4'hF, 2'h0);
            rd(`OFF_DIVIDER, d, 32'hFFFFFFFF, 2'h0, q);
            ref_period(n);
            `CHK("ref period", 2 * (d + 1), n)
        end
        complete_run();
    end
endmodule
